// file: rtl/brx_defines.vh
`ifndef BRX_DEFINES_VH
`define BRX_DEFINES_VH
// Register byte addresses
`define BRX_ADDR_BC_LOW 12'h510
`define BRX_ADDR_BC_HIGH 12'h514
`define BRX_ADDR_EC_LOW_STAT 12'h518
`define BRX_ADDR_EC_HIGH 12'h51c
`define BRX_ADDR_CTRL 12'h520
`define BRX_ADDR_IRQ_STAT 12'h524
`define BRX_ADDR_IRQ_MASK 12'h528
// Status field positions
`define BRX_ST_SYNC 0
`define BRX_ST_ECO 1
`define BRX_ST_BCO 2
`define BRX_ST_BED 3
`define BRX_ST_LOS 4
`define BRX_ST_RA0 5
`define BRX_ST_RA1 6
// Control field positions
`define BRX_CT_LOAD 0
// Interrupt status/mask bits
`define BRX_IRQ_OVF 0
`define BRX_IRQ_BED 1
`define BRX_IRQ_SYNC 2
// Synchroniser and detector counts
`define BRX_SYNC_MATCH 6'd32
`define BRX_LOS_WINDOW 7'd64
`define BRX_LOS_ERRS 3'd6
`define BRX_RUN_LEN 5'd31
`define BRX_RESET_VAL 16'h0000
`endif

// file: rtl/brx_bert_rx.v
`timescale 1ns/100ps
`include "brx_defines.vh"
module brx_bert_rx #(
  parameter BC_W = 32,
  parameter EC_W = 24
) (
  input wire REF_CLK, // System clock
  input wire RESET, // Synchronous reset, active high
  input wire RX_DATA, // Received bit, same clock domain
  input wire RX_EXP, // Expected pattern bit
  input wire RX_BIT_EN, // One-cycle pulse per received bit
  input wire [11:0] AVS_ADDRESS, // Byte address
  input wire AVS_READ, // Read strobe
  input wire AVS_WRITE, // Write strobe
  input wire [31:0] AVS_WRITEDATA, // Write data
  input wire [3:0] AVS_BYTEENABLE, // Byte enables
  output reg [31:0] AVS_READDATA, // Read data
  output wire AVS_WAITREQUEST, // Wait request
  output wire IRQ // Level interrupt
);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle per access; ack_q marks the completing cycle
  reg ack_q;
  wire req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  wire rd_done = AVS_READ & ack_q;
  wire wr_done = AVS_WRITE & ack_q;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function sel;
    input [11:0] a;
    input [11:0] b;
    begin
      sel = (a[11:2] == b[11:2]);
    end
  endfunction

  wire rd_stat = rd_done & sel(AVS_ADDRESS, `BRX_ADDR_EC_LOW_STAT);
  wire wr_ctrl = wr_done & sel(AVS_ADDRESS, `BRX_ADDR_CTRL) & AVS_BYTEENABLE[0];
  wire wr_ctrl_hi = wr_done & sel(AVS_ADDRESS, `BRX_ADDR_CTRL) & AVS_BYTEENABLE[1];
  wire wr_istat = wr_done & sel(AVS_ADDRESS, `BRX_ADDR_IRQ_STAT) & AVS_BYTEENABLE[0];
  wire wr_imask = wr_done & sel(AVS_ADDRESS, `BRX_ADDR_IRQ_MASK) & AVS_BYTEENABLE[0];

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  reg [BC_W-1:0] bit_cnt_q;
  reg [EC_W-1:0] err_cnt_q;
  reg [BC_W-1:0] bit_snap_q;
  reg [EC_W-1:0] err_snap_q;
  reg load_q;
  reg sync_q;
  wire bit_err = RX_BIT_EN & (RX_DATA ^ RX_EXP);
  wire bc_full = &bit_cnt_q;
  wire ec_full = &err_cnt_q;
  wire bc_ovf = RX_BIT_EN & ~bc_full & (&bit_cnt_q[BC_W-1:1]);
  wire ec_ovf = bit_err & ~ec_full & (&err_cnt_q[EC_W-1:1]);
  wire load_ctl = load_q;
  reg load_prev_q;
  wire load_rise = load_ctl & ~load_prev_q;

  always @(posedge REF_CLK) begin
    if (RESET) begin
      bit_cnt_q <= {BC_W{1'b0}};
      err_cnt_q <= {EC_W{1'b0}};
      bit_snap_q <= {BC_W{1'b0}};
      err_snap_q <= {EC_W{1'b0}};
      load_prev_q <= 1'b0;
    end else begin
      load_prev_q <= load_ctl;
      // Counting never depends on sync_q
      if (RX_BIT_EN && !bc_full) begin
        bit_cnt_q <= bit_cnt_q + {{(BC_W-1){1'b0}}, 1'b1};
      end
      if (bit_err && !ec_full) begin
        err_cnt_q <= err_cnt_q + {{(EC_W-1){1'b0}}, 1'b1};
      end
      if (load_rise) begin
        bit_snap_q <= bit_cnt_q;
        err_snap_q <= err_cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // While hunting, a run of matches locks; in sync, errors in a fixed
  // 64-bit window decide loss. Window is block based, not sliding.
  reg [5:0] match_q;
  reg [6:0] win_q;
  reg [2:0] werr_q;
  wire lose = bit_err & (werr_q == `BRX_LOS_ERRS - 3'd1);
  wire gain = RX_BIT_EN & ~bit_err & (match_q == `BRX_SYNC_MATCH - 6'd1);
  always @(posedge REF_CLK) begin
    if (RESET) begin
      sync_q <= 1'b0;
      match_q <= 6'd0;
      win_q <= 7'd0;
      werr_q <= 3'd0;
    end else if (RX_BIT_EN) begin
      if (!sync_q) begin
        win_q <= 7'd0;
        werr_q <= 3'd0;
        if (bit_err) begin
          match_q <= 6'd0;
        end else if (gain) begin
          sync_q <= 1'b1;
          match_q <= 6'd0;
        end else begin
          match_q <= match_q + 6'd1;
        end
      end else if (lose) begin
        sync_q <= 1'b0;
        win_q <= 7'd0;
        werr_q <= 3'd0;
      end else if (win_q == `BRX_LOS_WINDOW - 7'd1) begin
        win_q <= 7'd0;
        werr_q <= 3'd0;
      end else begin
        win_q <= win_q + 7'd1;
        werr_q <= werr_q + {2'b00, bit_err};
      end
    end
  end

  // ----------------------------------------------------------------
  // Run detectors
  // ----------------------------------------------------------------
  reg [4:0] zrun_q;
  reg [4:0] orun_q;
  wire zero_hit = RX_BIT_EN & ~RX_DATA & (zrun_q == `BRX_RUN_LEN - 5'd1);
  wire one_hit = RX_BIT_EN & RX_DATA & (orun_q == `BRX_RUN_LEN - 5'd1);
  always @(posedge REF_CLK) begin
    if (RESET) begin
      zrun_q <= 5'd0;
      orun_q <= 5'd0;
    end else if (RX_BIT_EN) begin
      if (RX_DATA) begin
        zrun_q <= 5'd0;
        orun_q <= (orun_q == `BRX_RUN_LEN) ? orun_q : orun_q + 5'd1;
      end else begin
        orun_q <= 5'd0;
        zrun_q <= (zrun_q == `BRX_RUN_LEN) ? zrun_q : zrun_q + 5'd1;
      end
    end
  end
  wire zeros_now = (zrun_q == `BRX_RUN_LEN);
  wire ones_now = (orun_q == `BRX_RUN_LEN);

  // ----------------------------------------------------------------
  // Latched status flags
  // ----------------------------------------------------------------
  reg eco_q;
  reg bco_q;
  reg bed_q;
  reg los_q;
  reg ra0_q;
  reg ra1_q;
  wire hunt_start = sync_q & lose;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      eco_q <= 1'b0;
      bco_q <= 1'b0;
      bed_q <= 1'b0;
      los_q <= 1'b0;
      ra0_q <= 1'b0;
      ra1_q <= 1'b0;
    end else begin
      // Set terms come last so an event beats the read clear
      if (rd_stat) begin
        eco_q <= 1'b0;
        bco_q <= 1'b0;
        bed_q <= 1'b0;
        los_q <= 1'b0;
        // Run flags may only clear once the run is broken
        if (!zeros_now) begin
          ra0_q <= 1'b0;
        end
        if (!ones_now) begin
          ra1_q <= 1'b0;
        end
      end
      if (ec_ovf) begin
        eco_q <= 1'b1;
      end
      if (bc_ovf) begin
        bco_q <= 1'b1;
      end
      if (bit_err && sync_q) begin
        bed_q <= 1'b1;
      end
      if (hunt_start) begin
        los_q <= 1'b1;
      end
      if (zero_hit) begin
        ra0_q <= 1'b1;
      end
      if (one_hit) begin
        ra1_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, interrupt status and mask
  // ----------------------------------------------------------------
  reg ie_ovf_q;
  reg ie_bed_q;
  reg ie_sync_q;
  reg [2:0] ist_q;
  reg [2:0] imask_q;
  wire [2:0] iev;
  assign iev[`BRX_IRQ_OVF] = ec_ovf | bc_ovf;
  assign iev[`BRX_IRQ_BED] = bit_err & sync_q;
  assign iev[`BRX_IRQ_SYNC] = gain & ~sync_q | hunt_start;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      load_q <= 1'b0;
      ie_ovf_q <= 1'b0;
      ie_bed_q <= 1'b0;
      ie_sync_q <= 1'b0;
      ist_q <= 3'h0;
      imask_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        load_q <= AVS_WRITEDATA[`BRX_CT_LOAD];
      end
      if (wr_ctrl_hi) begin
        ie_ovf_q <= AVS_WRITEDATA[13];
        ie_bed_q <= AVS_WRITEDATA[14];
        ie_sync_q <= AVS_WRITEDATA[15];
      end
      if (wr_imask) begin
        imask_q <= AVS_WRITEDATA[2:0];
      end
      // Write one to clear; new events win
      ist_q <= (ist_q & ~(wr_istat ? AVS_WRITEDATA[2:0] : 3'h0)) | iev;
    end
  end
  wire [2:0] ien = {ie_sync_q, ie_bed_q, ie_ovf_q};
  assign IRQ = |(ist_q & imask_q & ien);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Snapshots widened to the register layout; narrow builds read zeros above
  reg [31:0] bit_snap_x;
  reg [23:0] err_snap_x;
  always @* begin
    bit_snap_x = 32'h00000000;
    bit_snap_x[BC_W-1:0] = bit_snap_q;
    err_snap_x = 24'h000000;
    err_snap_x[EC_W-1:0] = err_snap_q;
  end
  wire [15:0] stat_word = {err_snap_x[7:0], 1'b0, ra1_q, ra0_q, los_q, bed_q,
                           bco_q, eco_q, sync_q};
  always @(posedge REF_CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & ~ack_q) begin
      case ({2'b00, AVS_ADDRESS[11:2]})
        `BRX_ADDR_BC_LOW >> 2: AVS_READDATA <= {16'h0000, bit_snap_x[15:0]};
        `BRX_ADDR_BC_HIGH >> 2: AVS_READDATA <= {16'h0000, bit_snap_x[31:16]};
        `BRX_ADDR_EC_LOW_STAT >> 2: AVS_READDATA <= {16'h0000, stat_word};
        `BRX_ADDR_EC_HIGH >> 2: AVS_READDATA <= {16'h0000, err_snap_x[23:8]};
        `BRX_ADDR_CTRL >> 2: AVS_READDATA <= {16'h0000, ie_sync_q, ie_bed_q,
                                               ie_ovf_q, 12'h000, load_q};
        `BRX_ADDR_IRQ_STAT >> 2: AVS_READDATA <= {29'h00000000, ist_q};
        `BRX_ADDR_IRQ_MASK >> 2: AVS_READDATA <= {29'h00000000, imask_q};
        default: AVS_READDATA <= 32'h00000000;
      endcase
    end
  end
endmodule

// file: testbench/brx_bit_src.sv
`timescale 1ns/100ps
module brx_bit_src (
  input wire clk, // Clock
  input wire go, // Bit each cycle
  input wire err, // Invert data
  input wire [1:0] fill, // [1] fixed, [0] level
  output wire d, // Bit
  output wire e, // Expected
  output wire en // Strobe
);
  // ----
  // Alternating pattern; idle line toggles so no stale bit shows
  // ----
  reg ph_q = 1'b0;
  reg t_q = 1'b0;
  always @(posedge clk) begin
    ph_q <= go ? ~ph_q : ph_q;
    t_q <= ~t_q;
  end
  assign en = go;
  assign e = ph_q;
  assign d = !go ? t_q : fill[1] ? fill[0] : ph_q ^ err;
endmodule

// file: testbench/brx_bert_rx_properties.sv
`timescale 1ns/100ps
module brx_bert_rx_chk #(
  parameter BC_W = 32,
  parameter EC_W = 24
) (
  input wire REF_CLK, // Clock
  input wire RESET, // Reset
  input wire RX_DATA, // Bit
  input wire RX_EXP, // Expected
  input wire RX_BIT_EN, // Strobe
  input wire [11:0] AVS_ADDRESS, // Address
  input wire AVS_READ, // Read
  input wire AVS_WRITE, // Write
  input wire [31:0] AVS_WRITEDATA, // Data
  input wire [3:0] AVS_BYTEENABLE, // Lanes
  input wire [31:0] AVS_READDATA, // Read data
  input wire AVS_WAITREQUEST, // Wait
  input wire IRQ // Interrupt
);
  // ----
  // Run lengths saturate at 63; thresholds leave slack for latency
  // ----
  reg [5:0] z_q, o_q, m_q, e_q;
  reg eco_q, bco_q;
  wire st = AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[11:2] == 10'h146;
  wire mm = RX_DATA ^ RX_EXP;
  always @(posedge REF_CLK) begin
    z_q <= RESET || (RX_BIT_EN && RX_DATA) ? 6'h0 : z_q + {5'h0, RX_BIT_EN && z_q != 6'h3f};
    o_q <= RESET || (RX_BIT_EN && !RX_DATA) ? 6'h0 : o_q + {5'h0, RX_BIT_EN && o_q != 6'h3f};
    m_q <= RESET || (RX_BIT_EN && mm) ? 6'h0 : m_q + {5'h0, RX_BIT_EN && m_q != 6'h3f};
    e_q <= RESET || (RX_BIT_EN && !mm) ? 6'h0 : e_q + {5'h0, RX_BIT_EN && e_q != 6'h3f};
    eco_q <= RESET ? 1'b0 : eco_q | (st & AVS_READDATA[1]);
    bco_q <= RESET ? 1'b0 : bco_q | (st & AVS_READDATA[2]);
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  chk_zero_run: assert property (st && z_q >= 6'd34 |-> AVS_READDATA[5])
    else $error("all-zeros flag missing");
  chk_one_run: assert property (st && o_q >= 6'd34 |-> AVS_READDATA[6])
    else $error("all-ones flag missing");
  chk_sync_up: assert property (st && m_q >= 6'd36 |-> AVS_READDATA[0])
    else $error("sync not reported");
  chk_sync_down: assert property (st && e_q >= 6'd16 |-> !AVS_READDATA[0])
    else $error("sync kept under errors");
  chk_eco_once: assert property (st && eco_q |-> !AVS_READDATA[1])
    else $error("error overflow set again");
  chk_bco_once: assert property (st && bco_q |-> !AVS_READDATA[2])
    else $error("bit overflow set again");
  chk_wait_state: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1
    !AVS_WAITREQUEST) else $error("wait state wrong");
  chk_reset_quiet: assert property ($fell(RESET) |-> AVS_READDATA == 32'h0 && !IRQ)
    else $error("outputs not clear after reset");
  cov_sync: cover property (st && AVS_READDATA[0]);
  cov_irq: cover property ($rose(IRQ));
  cov_bco: cover property (st && AVS_READDATA[2]);
endmodule
bind brx_bert_rx brx_bert_rx_chk #(.BC_W(BC_W), .EC_W(EC_W)) chk_u (.REF_CLK(REF_CLK),
  .RESET(RESET), .RX_DATA(RX_DATA), .RX_EXP(RX_EXP), .RX_BIT_EN(RX_BIT_EN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));

// file: testbench/brx_bert_rx_bench.sv
`timescale 1ns/100ps
module brx_bert_rx_bench;
  logic clk, rst, rd_s, wr_s, go, er, irq, wreq, d, e, en, ph;
  logic [1:0] fl;
  logic [11:0] adr;
  logic [31:0] wd, rdat, q;
  int errors, n_compared, nb, ne;
  brx_bit_src src_u (.clk(clk), .go(go), .err(er), .fill(fl), .d(d), .e(e), .en(en));
  // Small counters so saturation is reached in a short run
  brx_bert_rx #(.BC_W(10), .EC_W(8)) dut_u (.REF_CLK(clk), .RESET(rst), .RX_DATA(d),
    .RX_EXP(e), .RX_BIT_EN(en), .AVS_ADDRESS(adr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .IRQ(irq));
  task cmp(input logic [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task rd(input logic [11:0] a);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk iff wreq === 1'b0);
    q = rdat;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    adr <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk iff wreq === 1'b0);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task chk(input logic [11:0] a, input logic [31:0] m, x);
    rd(a);
    cmp(q & m, x);
  endtask
  task ic(input logic x);
    @(negedge clk);
    cmp({31'h0, irq}, {31'h0, x});
    @(posedge clk);
  endtask
  task sb(input int n, input logic r, input logic [1:0] f);
    for (int i = 0; i < n; i++) begin
      go <= 1'b1;
      er <= r;
      fl <= f;
      nb++;
      ne += ((f[1] ? f[0] : ph ^ r) !== ph);
      ph = ~ph;
      @(posedge clk);
    end
    go <= 1'b0;
    @(posedge clk);
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // Clock, watchdog and test sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    {rd_s, wr_s, go, er, fl, adr, wd, ph} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) chk(12'h510 + 12'(4 * i), 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(12'h528, 32'h7);
    wr(12'h520, 32'he000);
    sb(40, 1'b0, 2'b00);
    chk(12'h518, 32'h1, 32'h1);
    ic(1'b1);
    wr(12'h524, 32'h4);
    ic(1'b0);
    sb(12, 1'b1, 2'b00);
    chk(12'h518, 32'h19, 32'h18);
    ic(1'b1);
    wr(12'h524, 32'h7);
    ic(1'b0);
    sb(4, 1'b1, 2'b00);
    chk(12'h518, 32'h19, 32'h0);
    $display("test sync done");
    sb(33, 1'b0, 2'b10);
    chk(12'h518, 32'h20, 32'h20);
    sb(34, 1'b0, 2'b11);
    rd(12'h518);
    chk(12'h518, 32'h60, 32'h40);
    sb(1, 1'b0, 2'b10);
    rd(12'h518);
    chk(12'h518, 32'h40, 32'h0);
    $display("test runs done");
    wr(12'h520, 32'h0);
    wr(12'h520, 32'h1);
    chk(12'h510, 32'hffff, 32'(nb));
    chk(12'h518, 32'hff00, 32'(ne << 8));
    chk(12'h51c, 32'hffff, 32'h0);
    $display("test counts done");
    wr(12'h528, 32'h1);
    wr(12'h520, 32'h2000);
    sb(1100, 1'b1, 2'b00);
    wr(12'h520, 32'h2001);
    ic(1'b1);
    chk(12'h510, 32'hffff, 32'h3ff);
    chk(12'h518, 32'hff06, 32'hff06);
    chk(12'h518, 32'h6, 32'h0);
    wr(12'h524, 32'h1);
    ic(1'b0);
    $display("test overflow done");
    print_verdict;
  end
endmodule
